// ===== led_cascade_consts.svh
// Purpose: constants of the cascaded led matrix brightness block
// Assumes: two driver ics per display, 25 MHz system clock
// Notes: definitions only
`ifndef LED_CASCADE_CONSTS_SVH
`define LED_CASCADE_CONSTS_SVH

`define NUM_IC 2
`define DOTS_PER_IC 160
`define CHAIN_BITS 320
`define COLS_PER_IC 20
`define ROWS 8
`define CTRL_BITS 8
`define ROW_CYCLES 64
`define BLANK_CYCLES 6'h04
`define LAST_PHASE 6'h3F
`define FIFO_DEPTH 32
`define FIFO_WIDTH 9
// display tick period, half the internal oscillator output period, in system clocks, value is a free choice
`define INT_OSC_DIV 8'h20
`define EXT_PRESCALE 3'h7
`define WORD_SEL_BIT 7
`define SLEEP_BIT 6
`define PEAK_HI 5
`define PEAK_LO 4
`define PWM_HI 3
`define SIMUL_BIT 0
`define PRESCALE_BIT 1
`define CTRL_RESET 7'h00

`endif

// ===== led_cascade_pkg.sv
// Purpose: shared types of the cascaded led matrix brightness block
// Assumes: nothing
// Notes: constants live in led_cascade_consts.svh
package led_cascade_pkg;
	typedef enum logic [2:0] {
		PUSH_IDLE = 3'b001,
		PUSH_HI = 3'b010,
		PUSH_LO = 3'b100
	} push_state_type;
	typedef logic [6:0] ctrl_word_type;
	typedef logic [5:0] cycles_type;
endpackage

// ===== ctrl_fifo.sv
// Purpose: synchronous fifo for control word updates
// Assumes: single clock, synchronous active high reset
// Notes: full and empty come from pointers with a wrap bit
`timescale 1ns/1ns
`default_nettype none
module ctrl_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 32
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// filling side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// draining side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr;
	logic [AW:0] rd_ptr;
	logic full;
	logic empty;

	assign empty = (wr_ptr == rd_ptr);
	assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
	assign in_ready_o = !full;
	assign out_valid_o = !empty;
	assign out_data_o = mem[rd_ptr[AW-1:0]];

	always_ff @(posedge clk_i) begin
		if (in_valid_i && !full) begin
			mem[wr_ptr[AW-1:0]] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			wr_ptr <= '0;
		end else if (in_valid_i && !full) begin
			wr_ptr <= wr_ptr + 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			rd_ptr <= '0;
		end else if (out_ready_i && !empty) begin
			rd_ptr <= rd_ptr + 1'b1;
		end
	end
endmodule
`default_nettype wire

// ===== led_cascade_display.sv
// Purpose: two chained led driver ics with pwm and peak current brightness
// Assumes: serial clock is its own domain and may stop outside frames
// Notes: dot and control shift data are stable while select is high
`timescale 1ns/1ns
`default_nettype none
`include "led_cascade_consts.svh"
module led_cascade_display
	import led_cascade_pkg::*;
(
	// system clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// serial link from host
	input wire logic ser_clk_i,
	input wire logic sel_n_i,
	input wire logic register_select_i,
	input wire logic din_i,
	input wire logic blank_line_i,
	output logic dout_o,
	// oscillator sharing
	input wire logic osc_slave_i,
	input wire logic ext_osc_i,
	output logic osc_o,
	// led drive, ic 0 in low bits
	output logic [15:0] row_o,
	output logic [39:0] col_o,
	output logic [3:0] peak_pixel_current_o
);
	// ------------------------------------------------------------
	// link domain: shift chains
	// ------------------------------------------------------------
	logic link_rst_s1;
	logic link_rst;
	logic [`CHAIN_BITS-1:0] dot_chain;
	logic [`CTRL_BITS-1:0] ctrl_shift [`NUM_IC];
	logic rs_link;
	logic [1:0] simul_s1;
	logic [1:0] simul_link;
	logic ic1_out;
	logic ic0_in;
	logic next_dout;
	ctrl_word_type cw0 [`NUM_IC];
	ctrl_word_type cw1 [`NUM_IC];

	always_ff @(posedge ser_clk_i) begin
		link_rst_s1 <= sys_rst_i;
		link_rst <= link_rst_s1;
	end

	always_ff @(posedge ser_clk_i) begin
		simul_s1 <= {cw1[1][`SIMUL_BIT], cw1[0][`SIMUL_BIT]};
		simul_link <= simul_s1;
	end

	// second ic is nearest the input pin, first ic feeds the output
	// limitation: after a mode change dout follows from the third link edge on
	assign ic1_out = simul_link[1] ? din_i : ctrl_shift[1][`CTRL_BITS-1];
	assign ic0_in = ic1_out;
	assign next_dout = register_select_i ?
		(simul_link[0] ? ic0_in : ctrl_shift[0][`CTRL_BITS-1]) : dot_chain[0];

	// new bits enter at the top so the first bit loaded lands at location 0
	always_ff @(posedge ser_clk_i) begin
		if (!sel_n_i && !register_select_i) begin
			dot_chain <= {din_i, dot_chain[`CHAIN_BITS-1:1]};
		end
	end

	// second ic always takes the serial stream, simultaneous mode is resolved at the latch
	always_ff @(posedge ser_clk_i) begin
		if (!sel_n_i && register_select_i) begin
			ctrl_shift[1] <= {ctrl_shift[1][`CTRL_BITS-2:0], din_i};
			ctrl_shift[0] <= {ctrl_shift[0][`CTRL_BITS-2:0], ctrl_shift[1][`CTRL_BITS-1]};
		end
	end

	always_ff @(posedge ser_clk_i) begin
		if (!sel_n_i) begin
			rs_link <= register_select_i;
		end
	end

	// registered output: one stage later than a bare pass-through
	always_ff @(posedge ser_clk_i) begin
		if (link_rst) begin
			dout_o <= 1'b0;
		end else if (!sel_n_i) begin
			dout_o <= next_dout;
		end
	end

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic [3:0] pin_s1;
	logic [3:0] pin_s2;
	logic sel_prev;
	logic ext_prev;
	logic latch_evt;
	logic ext_rise;
	logic ext_sel;
	logic blank_s;

	always_ff @(posedge clk_i) begin
		pin_s1 <= {sel_n_i, ext_osc_i, osc_slave_i, blank_line_i};
		pin_s2 <= pin_s1;
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			sel_prev <= 1'b1;
			ext_prev <= 1'b0;
		end else begin
			sel_prev <= pin_s2[3];
			ext_prev <= pin_s2[2];
		end
	end

	assign latch_evt = pin_s2[3] && !sel_prev;
	assign ext_rise = pin_s2[2] && !ext_prev;
	assign ext_sel = pin_s2[1];
	assign blank_s = pin_s2[0];

	// ------------------------------------------------------------
	// latch: dots copied directly, control words queued
	// ------------------------------------------------------------
	logic [`CHAIN_BITS-1:0] dot_latch;
	logic [`CTRL_BITS-1:0] ctrl_hold [`NUM_IC];
	push_state_type push_state;
	logic in_valid;
	logic in_ready;
	logic [`FIFO_WIDTH-1:0] in_data;
	logic out_valid;
	logic out_ready;
	logic [`FIFO_WIDTH-1:0] out_data;

	always_ff @(posedge clk_i) begin
		if (latch_evt && !rs_link) begin
			dot_latch <= dot_chain;
		end
	end

	always_ff @(posedge clk_i) begin
		if (latch_evt && rs_link && push_state == PUSH_IDLE) begin
			// link copy of the mode lags two link edges, so the word is picked here
			ctrl_hold[0] <= cw1[1][`SIMUL_BIT] ? ctrl_shift[1] : ctrl_shift[0];
			ctrl_hold[1] <= ctrl_shift[1];
		end
	end

	// pushes wait on fifo ready, a latch during a push is dropped
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			push_state <= PUSH_IDLE;
		end else begin
			case (push_state)
				PUSH_IDLE: begin
					if (latch_evt && rs_link) begin
						push_state <= PUSH_HI;
					end
				end
				PUSH_HI: begin
					if (in_ready) begin
						push_state <= PUSH_LO;
					end
				end
				PUSH_LO: begin
					if (in_ready) begin
						push_state <= PUSH_IDLE;
					end
				end
				default: push_state <= PUSH_IDLE;
			endcase
		end
	end

	assign in_valid = (push_state == PUSH_HI) || (push_state == PUSH_LO);
	assign in_data = (push_state == PUSH_HI) ? {1'b1, ctrl_hold[1]} : {1'b0, ctrl_hold[0]};

	ctrl_fifo #(
		.WIDTH(`FIFO_WIDTH),
		.DEPTH(`FIFO_DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.in_valid_i(in_valid),
		.in_ready_o(in_ready),
		.in_data_i(in_data),
		.out_valid_o(out_valid),
		.out_ready_i(out_ready),
		.out_data_o(out_data)
	);

	// ------------------------------------------------------------
	// control words, applied only between rows or while both ics sleep
	// ------------------------------------------------------------
	logic disp_tick;
	logic [8:0] disp_cnt;
	logic [5:0] phase;
	logic [2:0] row;
	logic [1:0] awake;
	logic row_end;

	assign phase = disp_cnt[5:0];
	assign row = disp_cnt[8:6];
	assign awake = {cw0[1][`SLEEP_BIT], cw0[0][`SLEEP_BIT]};
	assign row_end = disp_tick && (phase == `LAST_PHASE);
	// changes land at a row edge, or at once while both ics sleep, so no row shows a torn brightness
	assign out_ready = row_end || (awake == 2'b00);

	genvar gi;
	generate
		for (gi = 0; gi < `NUM_IC; gi++) begin : g_ctrl
			always_ff @(posedge clk_i) begin
				if (sys_rst_i) begin
					cw0[gi] <= `CTRL_RESET;
					cw1[gi] <= `CTRL_RESET;
				end else if (out_valid && out_ready && out_data[8] == 1'(gi)) begin
					if (out_data[`WORD_SEL_BIT]) begin
						cw1[gi] <= out_data[6:0];
					end else begin
						cw0[gi] <= out_data[6:0];
					end
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// display oscillator and refresh counter
	// ------------------------------------------------------------
	logic [7:0] int_div;
	logic int_tick;
	logic [2:0] ext_div;
	logic ext_tick;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i || awake == 2'b00) begin
			int_div <= 8'h00;
		end else if (int_div == `INT_OSC_DIV - 8'h01) begin
			int_div <= 8'h00;
		end else begin
			int_div <= int_div + 8'h01;
		end
	end

	assign int_tick = (awake != 2'b00) && (int_div == `INT_OSC_DIV - 8'h01);

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			osc_o <= 1'b0;
		end else if (int_tick) begin
			osc_o <= !osc_o;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			ext_div <= 3'h0;
		end else if (ext_rise) begin
			ext_div <= ext_div + 3'h1;
		end
	end

	assign ext_tick = ext_rise &&
		(!cw1[0][`PRESCALE_BIT] || ext_div == `EXT_PRESCALE);
	assign disp_tick = ext_sel ? (ext_tick && awake != 2'b00) : int_tick;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			disp_cnt <= 9'h000;
		end else if (disp_tick) begin
			disp_cnt <= disp_cnt + 9'h001;
		end
	end

	// ------------------------------------------------------------
	// pwm and drivers
	// ------------------------------------------------------------
	function automatic cycles_type on_time(input logic [3:0] code);
		case (code)
			4'h0: on_time = 6'd0;
			4'h1: on_time = 6'd1;
			4'h2: on_time = 6'd2;
			4'h3: on_time = 6'd3;
			4'h4: on_time = 6'd4;
			4'h5: on_time = 6'd5;
			4'h6: on_time = 6'd7;
			4'h7: on_time = 6'd9;
			4'h8: on_time = 6'd11;
			4'h9: on_time = 6'd14;
			4'hA: on_time = 6'd18;
			4'hB: on_time = 6'd22;
			4'hC: on_time = 6'd28;
			4'hD: on_time = 6'd36;
			4'hE: on_time = 6'd48;
			default: on_time = 6'd60;
		endcase
	endfunction

	logic [1:0] lit;
	logic [15:0] next_row;
	logic [39:0] next_col;
	genvar gc;
	generate
		for (gi = 0; gi < `NUM_IC; gi++) begin : g_drv
			// duty follows from the lit window over the 64-cycle row
			assign lit[gi] = awake[gi] && !blank_s && phase >= `BLANK_CYCLES &&
				(phase - `BLANK_CYCLES) < on_time(cw0[gi][`PWM_HI:0]);
			assign next_row[gi*8 +: 8] = lit[gi] ? (8'h01 << row) : 8'h00;
			for (gc = 0; gc < `COLS_PER_IC; gc++) begin : g_col
				assign next_col[gi*`COLS_PER_IC + gc] = lit[gi] &&
					dot_latch[gi*`DOTS_PER_IC + gc*`ROWS + row];
			end
		end
	endgenerate

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			row_o <= 16'h0000;
			col_o <= 40'h00_0000_0000;
		end else begin
			row_o <= next_row;
			col_o <= next_col;
		end
	end

	// 00 is the 73 percent reset default
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			peak_pixel_current_o <= 4'h0;
		end else begin
			peak_pixel_current_o <= {cw0[1][`PEAK_HI:`PEAK_LO], cw0[0][`PEAK_HI:`PEAK_LO]};
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	property p_row_single;
		$onehot0(row_o[7:0]) && $onehot0(row_o[15:8]);
	endproperty
	a_row_single: assert property (p_row_single) else $error("more than one row lit");

	property p_blank_gap;
		(row_o != 16'h0000) |-> $past(phase) >= `BLANK_CYCLES;
	endproperty
	a_blank_gap: assert property (p_blank_gap) else $error("row lit in blanking");

	property p_ontime;
		(row_o[7:0] != 8'h00) |-> ($past(phase) - 6'd4) < $past(on_time(cw0[0][3:0]));
	endproperty
	a_ontime: assert property (p_ontime) else $error("row lit past on-time");

	property p_full_on;
		awake[0] && !blank_s && cw0[0][3:0] == 4'hF && phase == `LAST_PHASE |=> row_o[7:0] != 8'h00;
	endproperty
	a_full_on: assert property (p_full_on) else $error("full pwm not lit");

	property p_sleep_dark;
		!cw0[0][`SLEEP_BIT] |=> row_o[7:0] == 8'h00 && col_o[19:0] == 20'h00000;
	endproperty
	a_sleep_dark: assert property (p_sleep_dark) else $error("sleeping ic drives leds");

	property p_osc_stop;
		awake == 2'b00 && !ext_sel |=> $stable(disp_cnt) && int_div == 8'h00;
	endproperty
	a_osc_stop: assert property (p_osc_stop) else $error("oscillator runs in sleep");

	property p_slave_tick;
		ext_sel && ext_rise && !cw1[0][`PRESCALE_BIT] && awake != 2'b00 |=>
			disp_cnt == $past(disp_cnt) + 9'h001;
	endproperty
	a_slave_tick: assert property (p_slave_tick) else $error("slave missed master edge");

	property p_peak;
		1'b1 |=> peak_pixel_current_o[1:0] == $past(cw0[0][5:4]);
	endproperty
	a_peak: assert property (p_peak) else $error("peak current not from word zero");

	property p_dot_copy;
		latch_evt && !rs_link |=> dot_latch == $past(dot_chain);
	endproperty
	a_dot_copy: assert property (p_dot_copy) else $error("dot chain not latched");

	c_row_lit: cover property (row_o[7:0] != 8'h00 && row_o[15:8] != 8'h00);
	c_ctrl_apply: cover property (out_valid && out_ready);
	c_slave_run: cover property (ext_sel && disp_tick);
	c_fifo_full: cover property (!in_ready);
endmodule
`default_nettype wire

// ===== host_bus_model.sv
// Purpose: host side of the shared serial display bus
// Assumes: link clock period 80 ns, stopped outside frames
// Notes: frames go out highest position first
`timescale 1ns/1ns
`default_nettype none
module host_bus_model (
	// system clock
	input wire logic clk_i,
	// shared bus lines, one set for every part
	output logic ser_clk_o,
	output logic sel_n_o,
	output logic register_select_o,
	output logic din_o,
	output logic blank_line_o
);
	initial begin
		ser_clk_o = 1'b0;
		sel_n_o = 1'b1;
		register_select_o = 1'b0;
		din_o = 1'b0;
		blank_line_o = 1'b0;
	end

	// ---------------------------------
	// control words
	// ---------------------------------
	function automatic logic [7:0] word0(input logic sleep, input logic [1:0] pk,
		input logic [3:0] pwm);
		return {1'b0, sleep, pk, pwm};
	endfunction

	// prescaler left low, bits two to six always low
	function automatic logic [7:0] word1(input logic simul);
		return {1'b1, 5'h00, 1'b0, simul};
	endfunction

	// ---------------------------------
	// frame transfer
	// ---------------------------------
	// select, register select and clock are one line for all parts
	// din feeds the right-most part; the return of the left-most is ignored
	task automatic send(input logic rs, input logic [319:0] v, input int n);
		@(posedge clk_i);
		#2;
		register_select_o = rs;
		sel_n_o = 1'b0;
		#17;
		for (int k = n - 1; k >= 0; k--) begin
			din_o = v[k];
			#40 ser_clk_o = 1'b1;
			#40 ser_clk_o = 1'b0;
		end
		#23 sel_n_o = 1'b1;
		// data held past the latch, then the idle line flips
		repeat (6) @(posedge clk_i);
		#2 din_o = ~din_o;
	endtask

	// one word for each ic, left ic first
	task automatic ctrl2(input logic [7:0] w_ic0, input logic [7:0] w_ic1);
		send(1'b1, {304'h0, w_ic0, w_ic1}, 16);
	endtask

	// one word reaching both ics in simultaneous mode
	task automatic ctrl1(input logic [7:0] w);
		send(1'b1, {312'h0, w}, 8);
	endtask

	task automatic set_blank(input logic b);
		@(posedge clk_i);
		#2 blank_line_o = b;
	endtask
endmodule
`default_nettype wire

// ===== tb_top.sv
// Purpose: self-checking bench of the cascaded led display
// Assumes: internal oscillator, 32 system clocks a display tick
// Notes: peak code changes are checked against a queue of notes
`timescale 1ns/1ns
`default_nettype none
`include "led_cascade_consts.svh"
`define CHK(what, exp, got) begin total_checks++; if ((got) !== (exp)) begin n_mismatch++; \
	$display("MISMATCH %s expected %0h seen %0h", what, exp, got); end end
module tb_top;
	logic clk_i;
	logic sys_rst_i;
	wire ser_clk, sel_n, rs, din, blank, dout, osc, ext_osc;
	logic slave, osc_prev;
	logic [2:0] ext_cnt = 3'h0;
	logic [7:0] row_prev;
	logic [15:0] row;
	logic [39:0] col;
	logic [3:0] peak, last_peak, cur_peak, e;
	logic [19:0] e0, e1;
	logic [319:0] dot, rev;
	logic [3:0] exp_q[$];
	logic [1:0] k;
	int n_mismatch, total_checks, l0, l1, m, cnt, o, s;
	int ontime[16] = '{0, 1, 2, 3, 4, 5, 7, 9, 11, 14, 18, 22, 28, 36, 48, 60};
	localparam int ROW_CLK = `ROW_CYCLES * `INT_OSC_DIV;
	// system clocks per master oscillator period, set by ext_cnt[2]
	localparam int EXT_CLK = 8;

	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	host_bus_model u_host (.clk_i(clk_i), .ser_clk_o(ser_clk), .sel_n_o(sel_n),
		.register_select_o(rs), .din_o(din), .blank_line_o(blank));

	led_cascade_display u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ser_clk_i(ser_clk),
		.sel_n_i(sel_n), .register_select_i(rs), .din_i(din), .blank_line_i(blank),
		.dout_o(dout), .osc_slave_i(slave), .ext_osc_i(ext_osc), .osc_o(osc), .row_o(row),
		.col_o(col), .peak_pixel_current_o(peak)); // own oscillator, slave at the end

	// stand-in for a master display's oscillator output
	always @(posedge clk_i) begin
		#2;
		ext_cnt <= ext_cnt + 3'h1;
	end
	assign ext_osc = ext_cnt[2];

	// ---------------------------------
	// helpers
	// ---------------------------------
	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// a whole row period of the internal oscillator, four rows in slave mode, so the sum does not depend on where it starts
	task automatic count_lit();
		l0 = 0;
		l1 = 0;
		m = 0;
		o = 0;
		s = 0;
		@(negedge clk_i);
		osc_prev = osc;
		row_prev = row[7:0];
		repeat (ROW_CLK) begin
			@(negedge clk_i);
			l0 += int'(|row[7:0]);
			l1 += int'(|row[15:8]);
			m += int'(!$onehot0(row[7:0]) || !$onehot0(row[15:8]));
			o += int'(osc !== osc_prev);
			s += int'(row[7:0] != 8'h00 && row_prev == 8'h00);
			osc_prev = osc;
			row_prev = row[7:0];
		end
	endtask

	// right ic is applied first, left one a row later
	task automatic note_peak(input logic [1:0] p0, input logic [1:0] p1);
		if (p1 !== cur_peak[3:2]) begin
			cur_peak[3:2] = p1;
			exp_q.push_back(cur_peak);
		end
		if (p0 !== cur_peak[1:0]) begin
			cur_peak[1:0] = p0;
			exp_q.push_back(cur_peak);
		end
	endtask

	task automatic settle();
		repeat (2 * ROW_CLK + 20) @(posedge clk_i);
	endtask

	always @(negedge clk_i) begin
		if (!sys_rst_i && peak !== last_peak) begin
			e = (exp_q.size() == 0) ? last_peak : exp_q.pop_front();
			`CHK("peak code", e, peak)
		end
		last_peak = peak;
	end

	// ---------------------------------
	// main sequence
	// ---------------------------------
	initial begin
		sys_rst_i = 1'b1;
		n_mismatch = 0;
		total_checks = 0;
		cur_peak = 4'h0;
		last_peak = 4'h0;
		slave = 1'b0;
		void'($urandom(32'h1EEC1531));
		repeat (3) @(posedge clk_i);
		#2 sys_rst_i = 1'b0;
		count_lit();
		`CHK("dark after reset", 0, l0 + l1)
		`CHK("reset peak", 4'h0, peak)
		$display("test reset done");

		for (int i = 0; i < 10; i++)
			dot[i*32 +: 32] = $urandom();
		rev = {<<{dot}};
		u_host.send(1'b0, rev, 320);
		u_host.ctrl2(u_host.word1(1'b0), u_host.word1(1'b0));
		note_peak(2'h0, 2'h3);
		u_host.ctrl2(u_host.word0(1'b1, 2'h0, 4'hF), u_host.word0(1'b1, 2'h3, 4'hF));
		settle();
		for (int r = 0; r < 8; r++) begin
			cnt = 0;
			do begin
				@(negedge clk_i);
				cnt++;
			end while (row[7:0] !== (8'h01 << r) && cnt < 20000);
			if (cnt >= 20000) begin
				n_mismatch++;
				end_sim();
			end
			for (int c = 0; c < 20; c++) begin
				e0[c] = dot[c*8+r];
				e1[c] = dot[160+c*8+r];
			end
			`CHK("right ic row", 8'h01 << r, row[15:8])
			`CHK("columns", {e1, e0}, col)
		end
		$display("test dot map done");

		for (int i = 0; i < 8; i++) begin
			k = 2'($urandom_range(0, 3));
			note_peak(2'(i), k);
			u_host.ctrl2(u_host.word0(1'b1, 2'(i), 4'(i)), u_host.word0(1'b1, k, 4'(15 - i)));
			// serial out, one register deep, holds the last bit of the frame before
			`CHK("serial out", (i == 0) ? 1'b1 : 1'(16 - i), dout)
			settle();
			count_lit();
			`CHK("left lit", ontime[i] * `INT_OSC_DIV, l0)
			`CHK("right lit", ontime[15-i] * `INT_OSC_DIV, l1)
			`CHK("one row at a time", 0, m)
			$display("test pwm step %0d done", i);
		end

		u_host.ctrl2(u_host.word1(1'b1), u_host.word1(1'b1));
		settle();
		k = 2'($urandom_range(0, 3));
		note_peak(k, k);
		u_host.ctrl1(u_host.word0(1'b1, k, 4'hF));
		settle();
		count_lit();
		`CHK("simultaneous lit", 2 * 60 * `INT_OSC_DIV, l0 + l1)
		`CHK("rows per window", 1, s)
		`CHK("oscillator output", `ROW_CYCLES, o)
		$display("test simultaneous done");

		u_host.ctrl1(u_host.word0(1'b0, k, 4'hF));
		settle();
		count_lit();
		`CHK("sleep dark", 0, l0 + l1)
		`CHK("oscillator stopped", 0, o)
		u_host.set_blank(1'b1);
		u_host.ctrl1(u_host.word0(1'b1, k, 4'hF));
		settle();
		count_lit();
		`CHK("blank dark", 0, l0 + l1)
		u_host.set_blank(1'b0);
		// let the blank pin pass its synchroniser first
		repeat (4) @(posedge clk_i);
		count_lit();
		`CHK("wake lit", 2 * 60 * `INT_OSC_DIV, l0 + l1)
		`CHK("pending peak notes", 0, exp_q.size())
		$display("test sleep and blank done");

		@(posedge clk_i);
		#2 slave = 1'b1;
		settle();
		count_lit();
		`CHK("slave lit", 2 * 60 * ROW_CLK / `ROW_CYCLES, l0 + l1)
		`CHK("slave rows", ROW_CLK / (`ROW_CYCLES * EXT_CLK), s)
		$display("test slave done");
		end_sim();
	end
endmodule
`default_nettype wire
